// >>> hdl/mem_fault_pkg.sv
// Constants and carrier types for the memory access fault status block.
// Assumes a single processor clock domain and a plain register port.
package mem_fault_pkg;

  localparam int unsigned ADDR_W         = 32;
  localparam int unsigned PRIO_W         = 8;

  // Byte address of the combined fault status word
  localparam logic [31:0] COMBINED_FAULT_STATUS_ADDR = 32'he000ed28;
  // Control word holding enable and priority (block-local choice)
  localparam logic [31:0] FAULT_CTRL_ADDR            = 32'he000ed24;
  // Captured fault address word
  localparam logic [31:0] FAULT_ADDR_ADDR            = 32'he000ed34;

  // Status field bit positions
  localparam int unsigned FETCH_BIT      = 0;
  localparam int unsigned DATA_BIT       = 1;
  localparam int unsigned EXIT_POP_BIT   = 3;
  localparam int unsigned ENTRY_PUSH_BIT = 4;
  localparam int unsigned LAZY_BIT       = 5;
  localparam int unsigned ADDR_VALID_BIT = 7;

  // Control word fields
  localparam int unsigned ENABLE_BIT     = 16;
  localparam int unsigned PRIO_LSB       = 0;

  localparam logic [7:0]  STATUS_RESET   = 8'h00;
  localparam logic [7:0]  STATUS_MASK_FPU   = 8'hbb;
  localparam logic [7:0]  STATUS_MASK_NOFPU = 8'h9b;

  // Private peripheral space and architectural execute-never ranges
  localparam logic [31:0] PPB_BASE       = 32'he0000000;
  localparam logic [31:0] PPB_LAST       = 32'he00fffff;
  localparam logic [31:0] XN_PERIPH_BASE = 32'h40000000;
  localparam logic [31:0] XN_PERIPH_LAST = 32'h5fffffff;
  localparam logic [31:0] XN_DEVICE_BASE = 32'ha0000000;

  typedef enum logic [2:0] {
    ACC_DATA       = 3'b000,
    ACC_FETCH      = 3'b001,
    ACC_ENTRY_PUSH = 3'b010,
    ACC_EXIT_POP   = 3'b011,
    ACC_LAZY       = 3'b100,
    ACC_VECTOR     = 3'b101
  } access_kind_t;

  // One access presented for checking
  typedef struct packed {
    logic              valid;
    access_kind_t      kind;
    logic [ADDR_W-1:0] addr;
    logic              write;
    logic              unprivileged;
  } access_req_t;

  // Protection unit verdict on that access
  typedef struct packed {
    logic enabled;
    logic hit;
    logic priv_only;
    logic read_only;
    logic exec_never;
  } region_attr_t;

  // Fault output towards the exception logic
  typedef struct packed {
    logic memory_access_fault;
    logic escalated_fault;
  } fault_out_t;

endpackage : mem_fault_pkg

// >>> hdl/access_violation_check.sv
// Combinational violation check of one access against region attributes.
// Assumes attributes come from the protection unit in the same cycle.
`timescale 1ns/100ps
`default_nettype none
module access_violation_check
  import mem_fault_pkg::*;
(
  input  wire access_req_t  req_i,
  input  wire region_attr_t attr_i,
  output logic              violation_o
);

  function automatic logic arch_xn(input logic [ADDR_W-1:0] a);
    arch_xn = (a >= XN_PERIPH_BASE && a <= XN_PERIPH_LAST) ||
              (a >= XN_DEVICE_BASE);
  endfunction : arch_xn

  logic is_ppb;
  logic is_exec;
  logic mpu_viol;

  always_comb begin
    is_ppb   = (req_i.addr >= PPB_BASE) && (req_i.addr <= PPB_LAST);
    is_exec  = (req_i.kind == ACC_FETCH);
    mpu_viol = 1'b0;
    if (attr_i.enabled) begin
      if (!attr_i.hit && !is_ppb)
        mpu_viol = 1'b1;                                         // [RULE_02]
      if (attr_i.hit && attr_i.priv_only && req_i.unprivileged)
        mpu_viol = 1'b1;                                         // [RULE_01]
      if (attr_i.hit && attr_i.read_only && req_i.write)
        mpu_viol = 1'b1;                                         // [RULE_03]
      if (attr_i.hit && attr_i.exec_never && is_exec)
        mpu_viol = 1'b1;                                         // [RULE_04]
    end
    // Architectural execute-never holds with or without protection
    violation_o = req_i.valid && (req_i.kind != ACC_VECTOR) &&   // [RULE_10]
                  (mpu_viol || (is_exec && arch_xn(req_i.addr))); // [RULE_11]
  end

endmodule : access_violation_check
`default_nettype wire

// >>> hdl/memory_access_fault_status.sv
// Memory access fault detection and sticky cause status.
// Assumes the pipeline presents one checked access per cycle and marks
// when a fetch that failed earlier reaches execute.
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
//
// Function
// RULE_01 - Unprivileged access to privileged-only region faults.
// RULE_02 - Protection on: unmapped access faults, private peripherals excepted.
// RULE_03 - Write to read-only location faults.
// RULE_04 - Fetch from execute-never region faults.
// RULE_05 - Checks cover data, fetches, entry pushes and exit pops.
// RULE_06 - Fetch violation faults only when instruction reaches execute.
// RULE_07 - Entry push violation sets bit 4.
// RULE_08 - Exit pop violation sets bit 3.
// RULE_09 - Lazy state violation sets bit 5, only with floating point.
// RULE_10 - Vector table fetches never fault.
// RULE_11 - Architectural execute-never fetches fault even without protection.
// RULE_12 - Data access violation sets bit 1.
// RULE_13 - Fetch access violation sets bit 0.
// RULE_14 - Address-valid bit 7 set when fault address captured.
// RULE_15 - Cause bits sticky until software writes one.
// RULE_16 - Shared address overwritten by other fault clears address-valid.
// RULE_17 - Software enables the fault by writing bit 16.
// RULE_18 - Software should set priority before enabling.
// RULE_19 - Disabled or non-preempting fault escalates instead.
// RULE_20 - Status sits in bits 7..0 of combined word, byte access.
// RULE_21 - Bits 2 and 6 read zero; reset clears all bits.
module memory_access_fault_status
  import mem_fault_pkg::*;
#(
  parameter bit HAS_FPU     = 1'b1,
  parameter bit SHARED_ADDR = 1'b0
) (
  input  wire logic              clock_i,
  input  wire logic              rst_b_i,
  input  wire access_req_t       req_i,
  input  wire region_attr_t      attr_i,
  input  wire logic              fetch_executes_i,
  input  wire logic              other_fault_addr_i,
  input  wire logic [PRIO_W-1:0] current_prio_i,
  input  wire logic [31:0]       reg_addr_i,
  input  wire logic [31:0]       reg_wdata_i,
  input  wire logic [3:0]        reg_be_i,
  input  wire logic              reg_write_i,
  input  wire logic              reg_read_i,
  output logic [31:0]            reg_rdata_o,
  output fault_out_t             fault_o,
  output logic [ADDR_W-1:0]      fault_addr_o
);

  localparam logic [7:0] STATUS_MASK =
    HAS_FPU ? STATUS_MASK_FPU : STATUS_MASK_NOFPU;

  typedef struct packed {
    logic [7:0]        status;
    logic              enable;
    logic [PRIO_W-1:0] prio;
    logic              fetch_pend;
    logic [ADDR_W-1:0] fault_addr;
    logic [31:0]       rdata;
    fault_out_t        fault;
  } state_t;

  state_t state;
  state_t next_state;
  logic   violation;

  access_violation_check u_check (
    .req_i       (req_i),
    .attr_i      (attr_i),
    .violation_o (violation)
  );

  function automatic logic [31:0] read_word(input state_t s,
                                             input logic [31:0] a);
    read_word = 32'h0000_0000;
    if (a == COMBINED_FAULT_STATUS_ADDR)
      read_word[7:0] = s.status & STATUS_MASK;                   // [RULE_20]
    else if (a == FAULT_CTRL_ADDR) begin
      read_word[ENABLE_BIT] = s.enable;
      read_word[PRIO_LSB +: PRIO_W] = s.prio;
    end else if (a == FAULT_ADDR_ADDR)
      read_word = s.fault_addr;
  endfunction : read_word

  logic [7:0] set_bits;
  logic [7:0] clr_bits;
  logic       raise;
  logic       capture;

  always_comb begin
    next_state = state;
    set_bits   = 8'h00;
    clr_bits   = 8'h00;
    raise      = 1'b0;
    capture    = 1'b0;

    // Fetch violations are held until the instruction executes
    if (violation && req_i.kind == ACC_FETCH) begin            // [RULE_06]
      next_state.fetch_pend = 1'b1;
    end
    if (state.fetch_pend && fetch_executes_i) begin
      set_bits[FETCH_BIT] = 1'b1;                                // [RULE_13]
      raise = 1'b1;
      if (!(violation && req_i.kind == ACC_FETCH))
        next_state.fetch_pend = 1'b0;
    end

    if (violation) begin                                         // [RULE_05]
      unique case (req_i.kind)
        ACC_DATA: begin
          set_bits[DATA_BIT] = 1'b1;                             // [RULE_12]
          capture = 1'b1;
          raise = 1'b1;
        end
        ACC_ENTRY_PUSH: begin
          set_bits[ENTRY_PUSH_BIT] = 1'b1;                       // [RULE_07]
          raise = 1'b1;
        end
        ACC_EXIT_POP: begin
          set_bits[EXIT_POP_BIT] = 1'b1;                         // [RULE_08]
          raise = 1'b1;
        end
        ACC_LAZY: begin
          set_bits[LAZY_BIT] = HAS_FPU;                          // [RULE_09]
          raise = 1'b1;
        end
        default: ;
      endcase
    end

    // Software write of ones clears; zeros leave bits alone
    if (reg_write_i && reg_be_i[0] &&
        reg_addr_i == COMBINED_FAULT_STATUS_ADDR)
      clr_bits = reg_wdata_i[7:0];                               // [RULE_15]
    if (reg_write_i && reg_addr_i == FAULT_CTRL_ADDR) begin
      if (reg_be_i[2])
        next_state.enable = reg_wdata_i[ENABLE_BIT];             // [RULE_17]
      if (reg_be_i[0])
        next_state.prio = reg_wdata_i[PRIO_LSB +: PRIO_W];       // [RULE_18]
    end

    if (capture) begin
      next_state.fault_addr = req_i.addr;
      set_bits[ADDR_VALID_BIT] = 1'b1;                           // [RULE_14]
    end

    // Set wins over a clear in the same cycle
    next_state.status = ((state.status & ~clr_bits) | set_bits)
                        & STATUS_MASK;                           // [RULE_21]
    if (SHARED_ADDR && other_fault_addr_i && !capture)
      next_state.status[ADDR_VALID_BIT] = 1'b0;                  // [RULE_16]

    // Lower value is higher priority
    next_state.fault.memory_access_fault =
      raise && state.enable && (state.prio < current_prio_i);
    next_state.fault.escalated_fault =
      raise && !(state.enable && (state.prio < current_prio_i)); // [RULE_19]

    next_state.rdata = reg_read_i ? read_word(state, reg_addr_i)
                                  : 32'h0000_0000;
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state        <= '0;
      state.status <= STATUS_RESET;                              // [RULE_21]
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata_o  = state.rdata;
  assign fault_o      = state.fault;
  assign fault_addr_o = state.fault_addr;

endmodule : memory_access_fault_status
`default_nettype wire

// >>> dv/mem_fault_monitor.sv
// Port assertions for the memory access fault status block.
// Assumes one clock domain and an active low asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
module mem_fault_monitor
  import mem_fault_pkg::*;
(
  input wire logic              clock_i,
  input wire logic              rst_b_i,
  input wire access_req_t       req_i,
  input wire region_attr_t      attr_i,
  input wire logic              fetch_executes_i,
  input wire logic [31:0]       reg_addr_i,
  input wire logic              reg_read_i,
  input wire logic [31:0]       reg_rdata_o,
  input wire fault_out_t        fault_o,
  input wire logic [ADDR_W-1:0] fault_addr_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  // Checked data access with protection on and no fetch retiring
  wire dv = req_i.valid && req_i.kind == ACC_DATA && attr_i.enabled
            && !fetch_executes_i;
  idle_read_a: assert property (
    !reg_read_i |=> reg_rdata_o == 32'h0)
    else $error("read data without a read");
  spare_bits_a: assert property (reg_read_i &&
    reg_addr_i == COMBINED_FAULT_STATUS_ADDR |=> reg_rdata_o[6] == 1'b0
    && reg_rdata_o[2] == 1'b0) else $error("spare status bit set");
  one_kind_a: assert property (
    !(fault_o.memory_access_fault && fault_o.escalated_fault))
    else $error("both fault kinds raised");
  vector_free_a: assert property (
    req_i.valid && req_i.kind == ACC_VECTOR
    && !fetch_executes_i |=> fault_o == '0) else $error("vector fetch fault");
  fetch_late_a: assert property (
    req_i.valid && req_i.kind == ACC_FETCH
    && !fetch_executes_i |=> fault_o == '0) else $error("early fetch fault");
  fault_cause_a: assert property (fault_o != '0
    |-> $past(req_i.valid || fetch_executes_i)) else $error("fault uncaused");
  unmapped_a: assert property (dv && !attr_i.hit &&
    req_i.addr[31:20] != 12'he00 |=> fault_o != '0
    && fault_addr_o == $past(req_i.addr)) else $error("unmapped missed");
  ppb_free_a: assert property (dv && !attr_i.hit &&
    req_i.addr[31:20] == 12'he00 |=> fault_o == '0) else $error("ppb fault");
  priv_only_a: assert property (dv && attr_i.hit &&
    attr_i.priv_only && req_i.unprivileged |=> fault_o != '0)
    else $error("privilege missed");
  read_only_a: assert property (dv && attr_i.hit &&
    attr_i.read_only && req_i.write |=> fault_o != '0)
    else $error("read-only missed");
  cover property (fault_o.memory_access_fault);
  cover property (fault_o.escalated_fault);
  cover property (fetch_executes_i ##1 fault_o != '0);
endmodule : mem_fault_monitor
bind memory_access_fault_status mem_fault_monitor mem_fault_monitor_inst (
  .clock_i(clock_i), .rst_b_i(rst_b_i), .req_i(req_i), .attr_i(attr_i),
  .fetch_executes_i(fetch_executes_i), .reg_addr_i(reg_addr_i),
  .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .fault_o(fault_o),
  .fault_addr_o(fault_addr_o));
`default_nettype wire

// >>> dv/memory_access_fault_status_test.sv
// Random bench comparing the fault status block with a behavioural model.
// Assumes each request is answered at the following clock edge.
`timescale 1ns/100ps
`default_nettype none
module memory_access_fault_status_test;
  import mem_fault_pkg::*;
  logic         clock_i = '0, rst_b_i = '0, fetch_executes_i = '0;
  logic         other_fault_addr_i = '0, reg_write_i = '0, reg_read_i = '0;
  logic         en = '0, pend = '0, fx, ofa, vi;
  logic [7:0]   current_prio_i = '0, st = '0, prio = '0, cp, clr, set;
  logic [3:0]   reg_be_i = '0, be;
  logic [1:0]   op;
  logic [31:0]  reg_addr_i = '0, reg_wdata_i = '0, reg_rdata_o, fault_addr_o;
  logic [31:0]  x = 32'h0000cb0e, rd = '0, fa = '0, erd, ea, ad, wd;
  access_req_t  req_i = '0, r;
  region_attr_t attr_i = '0, a;
  fault_out_t   fault_o, ef, nf = '0;
  int           miscompares = 0, check_count = 0;
  always #5 clock_i = ~clock_i;
  memory_access_fault_status #(.HAS_FPU(1'b1), .SHARED_ADDR(1'b1))
    memory_access_fault_status_inst (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .req_i(req_i), .attr_i(attr_i), .fetch_executes_i(fetch_executes_i),
    .other_fault_addr_i(other_fault_addr_i), .current_prio_i(current_prio_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_be_i(reg_be_i),
    .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
    .reg_rdata_o(reg_rdata_o), .fault_o(fault_o), .fault_addr_o(fault_addr_o));
  function automatic logic [31:0] rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : rnd
  function automatic logic viol(access_req_t q, region_attr_t m);
    logic xn;
    xn = q.kind == ACC_FETCH &&
         (q.addr[31:29] == 3'h2 || q.addr[31:29] > 3'h4);
    return q.valid && q.kind != ACC_VECTOR &&
      (xn || m.enabled && (m.hit ?
      (m.priv_only && q.unprivileged || m.read_only && q.write ||
       m.exec_never && q.kind == ACC_FETCH) : q.addr[31:20] != 12'he00));
  endfunction : viol
  task automatic check_value(input string what, input logic [31:0] got,
                             input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check_value
  task automatic check_fault(input fault_out_t got, input fault_out_t exp);
    check_value("fault", {30'h0, got}, {30'h0, exp});
  endtask : check_fault
  task automatic check_rdata(input logic [31:0] got, input logic [31:0] exp);
    check_value("read data", got, exp);
  endtask : check_rdata
  task automatic check_addr(input logic [31:0] got, input logic [31:0] exp);
    check_value("fault address", got, exp);
  endtask : check_addr
  task automatic results();
    $display("compares %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results
  initial begin
    #(4000 * 10);
    miscompares++;
    results();
  end
  initial begin
    repeat (8) @(posedge clock_i);
    rst_b_i <= 1'b1;
    for (int n = 0; n < 3000; n++) begin
      @(posedge clock_i);
      ef = nf;
      erd = rd;
      ea = fa;
      // Mid-run reset: outputs drop at once, this cycle's request is lost
      rst_b_i <= (n != 1500);
      if (n == 1500) begin
        ef = '0;
        erd = '0;
        ea = '0;
      end
      void'(rnd());
      a = region_attr_t'(x[4:0]);
      r.unprivileged = x[6];
      fx = x[8:7] == 2'h0;
      ofa = x[11:9] == 3'h0 && !fx;
      r.valid = !fx && !ofa && x[12] && n != 1500;
      op = x[14:13];
      ad = x[16:15] == 2'h1 ? FAULT_CTRL_ADDR : x[16:15] == 2'h2 ?
           FAULT_ADDR_ADDR : x[16:15] == 2'h3 ? 32'he000ed30 :
           COMBINED_FAULT_STATUS_ADDR;
      r.kind = access_kind_t'(3'(x[23:17] % 7'h6));
      r.write = (x[5] && r.kind == ACC_DATA) ||
                r.kind inside {ACC_ENTRY_PUSH, ACC_LAZY};
      cp = x[31:24];
      r.addr = rnd();
      if (x[1:0] == 2'h0) r.addr[31:20] = 12'he00;
      wd = rnd();
      be = wd[31:28];
      rd = op != 2'h2 ? '0 : ad == COMBINED_FAULT_STATUS_ADDR ? {24'h0, st} :
           ad == FAULT_CTRL_ADDR ? {15'h0, en, 8'h0, prio} :
           ad == FAULT_ADDR_ADDR ? fa : '0;
      vi = viol(r, a);
      nf = '0;
      if ((vi && r.kind != ACC_FETCH) || (fx && pend))
        nf = fault_out_t'((en && prio < cp) ? 2'h2 : 2'h1);
      set = !vi ? 8'h0 : r.kind == ACC_DATA ? 8'h82 :
            r.kind == ACC_ENTRY_PUSH ? 8'h10 :
            r.kind == ACC_EXIT_POP ? 8'h08 :
            r.kind == ACC_LAZY ? 8'h20 : 8'h0;
      if (fx && pend) set[0] = 1'b1;
      pend = (pend && !fx) || (vi && r.kind == ACC_FETCH);
      if (vi && r.kind == ACC_DATA) fa = r.addr;
      clr = (op == 2'h1 && ad == COMBINED_FAULT_STATUS_ADDR && be[0]) ?
            wd[7:0] : 8'h0;
      if (ofa) clr[7] = 1'b1;
      st = ((st & ~clr) | set) & STATUS_MASK_FPU;
      if (op == 2'h1 && ad == FAULT_CTRL_ADDR && be[2])
        en = wd[16];
      if (op == 2'h1 && ad == FAULT_CTRL_ADDR && be[0])
        prio = wd[7:0];
      if (n == 1500) begin
        nf = '0;
        rd = '0;
        fa = '0;
        st = '0;
        en = 1'b0;
        prio = '0;
        pend = 1'b0;
      end
      req_i <= r;
      attr_i <= a;
      fetch_executes_i <= fx;
      other_fault_addr_i <= ofa;
      current_prio_i <= cp;
      reg_write_i <= op == 2'h1;
      reg_read_i <= op == 2'h2;
      reg_addr_i <= ad;
      reg_wdata_i <= wd;
      reg_be_i <= be;
      @(negedge clock_i);
      check_fault(fault_o, ef);
      check_rdata(reg_rdata_o, erd);
      check_addr(fault_addr_o, ea);
    end
    results();
  end
endmodule : memory_access_fault_status_test
`default_nettype wire
